/* hw/pa_pkg.sv */
/*
  constants, field layout and carrier types of the eight-pin port block.
  assumes a 32-bit apb master and one 50 mhz clock domain.
*/
package pa_pkg;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [31:0] PA_CFG_ADDR = 32'hffb0_0020;
  localparam int          PA_PINS     = 8;
  localparam int          PA_FSEL_LSB = 24;
  localparam int          PA_DIR_LSB  = 16;
  localparam int          PA_VAL_LSB  = 0;
  localparam logic [7:0]  PA_RSVD_RD  = 8'h00;
  localparam logic [31:0] PA_RD_RST   = 32'h0000_0000;

  // ****************************************
  // pin roles and serial selects
  // ****************************************
  localparam int          PA_MUX_PIN  = 2;
  localparam logic [1:0]  PA_P4_MCLK  = 2'h0;
  localparam logic [1:0]  PA_P4_AUX1  = 2'h1;
  localparam logic [1:0]  PA_P4_RXC   = 2'h2;
  localparam logic        PA_P0_MSEL  = 1'h0;
  localparam logic        PA_P0_AUX2  = 1'h1;
  localparam logic [7:0]  PA_PAD_RST  = 8'h00;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic [7:0] fsel;
    logic [7:0] dir;
    logic [7:0] val;
  } pa_cfg_t;

  localparam pa_cfg_t PA_CFG_RST = '{fsel: 8'h00, dir: 8'h00, val: 8'h00};

  typedef struct packed {
    logic chanATxData;
    logic chanATerminalReadyN;
    logic chanARequestSendN;
    logic chanAMasterClock;
    logic chanAAuxOutOne;
    logic chanARxClockOut;
    logic dmaOneAckOut;
    logic memAddrMuxStrobe;
    logic dmaOneFinishedOutN;
    logic chanAMasterSelectN;
    logic chanAAuxOutTwo;
  } pa_sfout_t;

  typedef struct packed {
    logic dmaOneRequestIn;
    logic chanARingN;
    logic chanARxClock;
    logic chanASlaveClock;
    logic chanARxData;
    logic chanASetReadyN;
    logic chanAClearSend;
    logic chanACarrierDetectN;
    logic chanATxClock;
    logic chanASlaveSelectN;
    logic dmaOneFinishedInN;
  } pa_route_t;

  localparam pa_route_t PA_ROUTE_RST = 11'h22b;

  typedef enum logic [1:0] {
    PA_ST_IDLE = 2'b01,
    PA_ST_ACK  = 2'b10
  } pa_apb_st_t;

endpackage

/* hw/pa_sync.sv */
/*
  two-flop synchroniser for the eight port pads.
  assumes pad levels are asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pa_sync
  import pa_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [PA_PINS-1:0] padIn,
  output logic      [PA_PINS-1:0] padSync
);

  logic [PA_PINS-1:0] meta_reg;
  logic [PA_PINS-1:0] sync_reg;

  // only the second stage is read outside
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= PA_PAD_RST;
      sync_reg <= PA_PAD_RST;
    end else begin
      meta_reg <= padIn;
      sync_reg <= meta_reg;
    end
  end

  assign padSync = sync_reg;

endmodule
`default_nettype wire

/* hw/pa_apb_slave.sv */
/*
  apb slave front end for the single port register, one wait state.
  assumes the master holds the request until pready is seen high.
*/
`timescale 1ns/10ps
`default_nettype none
module pa_apb_slave
  import pa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] rdData,
  output logic             wrEn,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  pa_apb_st_t  st_reg;
  logic        hit;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  assign hit = (paddr == PA_CFG_ADDR);

  // ****************************************
  // handshake
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg      <= PA_ST_IDLE;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= PA_RD_RST;
    end else begin
      case (st_reg)
        PA_ST_IDLE: begin
          if (psel && penable) begin
            st_reg      <= PA_ST_ACK;
            pready_reg  <= 1'b1;
            pslverr_reg <= !hit;
            prdata_reg  <= (hit && !pwrite) ? rdData : PA_RD_RST;
          end
        end
        PA_ST_ACK: begin
          st_reg     <= PA_ST_IDLE;
          pready_reg <= 1'b0;
        end
        default: begin
          st_reg     <= PA_ST_IDLE;
          pready_reg <= 1'b0;
        end
      endcase
    end
  end

  // write lands on the completing edge only
  assign wrEn    = (st_reg == PA_ST_ACK) && psel && penable && pwrite && hit;
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

endmodule
`default_nettype wire

/* hw/pa_port_top.sv */
/*
  eight-pin general purpose port with special-function routing, apb
  register access, pad drivers and peripheral signal fan-out.
  assumes pads resolved outside from padOut/padOe, peripherals on clk.
*/
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module pa_port_top
  import pa_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [PA_PINS-1:0] padIn,
  output logic      [PA_PINS-1:0] padOut,
  output logic      [PA_PINS-1:0] padOe,
  input  wire pa_sfout_t          sfOut,
  input  wire logic [1:0]         chanAPin4Sel,
  input  wire logic               chanAPin0Sel,
  input  wire logic               memMuxEnable,
  output pa_route_t               route
);

  // ****************************************
  // declarations
  // ****************************************
  pa_cfg_t            cfg_reg;
  pa_cfg_t            cfg_next;
  pa_route_t          route_reg;
  logic [PA_PINS-1:0] padOut_reg;
  logic [PA_PINS-1:0] padOe_reg;
  logic [PA_PINS-1:0] padSync;
  logic [PA_PINS-1:0] gpoMask;
  logic [PA_PINS-1:0] readVal;
  logic [PA_PINS-1:0] sfVec;
  logic [PA_PINS-1:0] outNext;
  logic [PA_PINS-1:0] oeNext;
  logic [31:0]        rdData;
  logic               wrEn;

  function automatic logic [PA_PINS-1:0] gpioOutMask(
    input logic [PA_PINS-1:0] fsel,
    input logic [PA_PINS-1:0] dir
  );
    return ~fsel & dir;
  endfunction

  // ****************************************
  // pad input synchroniser and bus slave
  // ****************************************
  pa_sync u_sync (
    .clk     (clk),
    .rst     (rst),
    .padIn   (padIn),
    .padSync (padSync)
  );

  pa_apb_slave u_apb (
    .clk     (clk),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .rdData  (rdData),
    .wrEn    (wrEn),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // ****************************************
  // configuration register
  // ****************************************
  assign gpoMask = gpioOutMask(cfg_reg.fsel, cfg_reg.dir);

  // value mask uses the config in force before this write
  always_comb begin
    cfg_next = cfg_reg;
    if (wrEn) begin
      cfg_next.fsel = pwdata[PA_FSEL_LSB +: PA_PINS];
      cfg_next.dir  = pwdata[PA_DIR_LSB +: PA_PINS];
      cfg_next.val  = (cfg_reg.val & ~gpoMask)
                    | (pwdata[PA_VAL_LSB +: PA_PINS] & gpoMask);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= PA_CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ****************************************
  // readback
  // ****************************************
  // latch readback hides a shorted output pin
  generate
    for (genvar i = 0; i < PA_PINS; i++) begin : g_rd
      assign readVal[i] = gpoMask[i] ? cfg_reg.val[i] : padSync[i];
    end
  endgenerate

  assign rdData = {cfg_reg.fsel, cfg_reg.dir, PA_RSVD_RD, readVal};

  // ****************************************
  // special-function outputs
  // ****************************************
  always_comb begin
    sfVec[7] = sfOut.chanATxData;
    sfVec[6] = sfOut.chanATerminalReadyN;
    sfVec[5] = sfOut.chanARequestSendN;
    case (chanAPin4Sel)
      PA_P4_MCLK: sfVec[4] = sfOut.chanAMasterClock;
      PA_P4_AUX1: sfVec[4] = sfOut.chanAAuxOutOne;
      PA_P4_RXC:  sfVec[4] = sfOut.chanARxClockOut;
      default:    sfVec[4] = sfOut.chanAMasterClock;
    endcase
    sfVec[3] = sfOut.dmaOneAckOut;
    sfVec[2] = sfOut.memAddrMuxStrobe;
    sfVec[1] = sfOut.dmaOneFinishedOutN;
    sfVec[0] = (chanAPin0Sel == PA_P0_AUX2) ? sfOut.chanAAuxOutTwo
                                            : sfOut.chanAMasterSelectN;
  end

  // ****************************************
  // pad drive
  // ****************************************
  // special input on pins 7 and 5 leaves the driver off, nothing routed
  generate
    for (genvar i = 0; i < PA_PINS; i++) begin : g_pad
      if (i == PA_MUX_PIN) begin : g_mux
        assign outNext[i] = memMuxEnable ? sfOut.memAddrMuxStrobe
                          : (cfg_reg.fsel[i] ? sfVec[i]
                                             : cfg_reg.val[i]);
        assign oeNext[i]  = memMuxEnable | cfg_reg.dir[i];
      end else begin : g_std
        assign outNext[i] = cfg_reg.fsel[i] ? sfVec[i]
                                            : cfg_reg.val[i];
        assign oeNext[i]  = cfg_reg.dir[i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      padOut_reg <= PA_PAD_RST;
      padOe_reg  <= PA_PAD_RST;
    end else begin
      padOut_reg <= outNext;
      padOe_reg  <= oeNext;
    end
  end

  assign padOut = padOut_reg;
  assign padOe  = padOe_reg;

  // ****************************************
  // input fan-out
  // ****************************************
  // wired whatever the port mode; each user gates it itself
  always_ff @(posedge clk) begin
    if (rst) begin
      route_reg <= PA_ROUTE_RST;
    end else begin
      route_reg.dmaOneRequestIn     <= padSync[6];
      route_reg.chanARingN          <= padSync[4];
      route_reg.chanARxClock        <= padSync[4];
      route_reg.chanASlaveClock     <= padSync[4];
      route_reg.chanARxData         <= padSync[3];
      route_reg.chanASetReadyN      <= padSync[2];
      route_reg.chanAClearSend      <= padSync[1];
      route_reg.chanACarrierDetectN <= padSync[0];
      route_reg.chanATxClock        <= padSync[0];
      route_reg.chanASlaveSelectN   <= padSync[0];
      route_reg.dmaOneFinishedInN   <= padSync[0];
    end
  end

  assign route = route_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fsel_store: assert property (
    wrEn |=> cfg_reg.fsel == $past(pwdata[31:24]))
    else $error("function select not stored");

  a_dir_store: assert property (
    wrEn |=> cfg_reg.dir == $past(pwdata[23:16]))
    else $error("direction not stored");

  a_read_latch: assert property (
    $rose(pready) && !pwrite && !pslverr |->
      ((prdata[7:0] ^ $past(cfg_reg.val)) & $past(gpoMask)) == 8'h00)
    else $error("gpio output readback not from latch");

  a_read_pin: assert property (
    $rose(pready) && !pwrite && !pslverr |->
      ((prdata[7:0] ^ $past(padSync)) & ~$past(gpoMask)) == 8'h00)
    else $error("readback not from pin level");

  a_val_guard: assert property (
    wrEn |=> ((cfg_reg.val ^ $past(cfg_reg.val)) & ~$past(gpoMask))
      == 8'h00)
    else $error("value changed on non gpio output pin");

  a_val_write: assert property (
    wrEn |=> ((cfg_reg.val ^ $past(pwdata[7:0])) & $past(gpoMask))
      == 8'h00)
    else $error("gpio output value not written");

  a_gpio_drive: assert property (
    !cfg_reg.fsel[7] && cfg_reg.dir[7] |=>
      padOe[7] && padOut[7] == $past(cfg_reg.val[7]))
    else $error("pin 7 gpio output wrong");

  // two synchroniser flops and the fan-out flop
  a_route_wired: assert property (
    ##3 route.chanARxData == $past(padIn[3], 3)
      && route.dmaOneRequestIn == $past(padIn[6], 3))
    else $error("pin input not routed");

  // route still holds its reset value one edge after release
  a_route_pin0: assert property (
    !$past(rst) |-> route.dmaOneFinishedInN == $past(padSync[0])
      && route.chanASlaveSelectN == $past(padSync[0]))
    else $error("pin 0 input not fanned out");

  a_sf_drive: assert property (
    cfg_reg.fsel[7] && cfg_reg.dir[7] |=>
      padOut[7] == $past(sfOut.chanATxData))
    else $error("pin 7 special output wrong");

  a_sf_in_off: assert property (
    cfg_reg.fsel[5] && !cfg_reg.dir[5] |=> !padOe[5])
    else $error("pin 5 driven in unsupported mode");

  a_oe_follow: assert property (
    ((padOe ^ $past(cfg_reg.dir)) & 8'hfb) == 8'h00)
    else $error("driver enable not from direction");

  a_pin4_sel: assert property (
    cfg_reg.fsel[4] && cfg_reg.dir[4] && chanAPin4Sel == PA_P4_AUX1
      |=> padOut[4] == $past(sfOut.chanAAuxOutOne))
    else $error("pin 4 select wrong");

  a_mux_over: assert property (
    memMuxEnable |=> padOe[2]
      && padOut[2] == $past(sfOut.memAddrMuxStrobe))
    else $error("memory strobe not overriding pin 2");

  a_pin0_sel: assert property (
    cfg_reg.fsel[0] && cfg_reg.dir[0] && chanAPin0Sel == PA_P0_AUX2
      |=> padOut[0] == $past(sfOut.chanAAuxOutTwo))
    else $error("pin 0 select wrong");

  a_reset_clear: assert property (disable iff (1'b0)
    rst |=> cfg_reg == PA_CFG_RST && padOe == 8'h00 && !pready)
    else $error("reset did not clear port");

  a_ack_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  c_gpo_write: cover property (wrEn && gpoMask != 8'h00);
  c_read_ok: cover property ($rose(pready) && !pwrite && !pslverr);
  c_bad_addr: cover property ($rose(pready) && pslverr);
  c_mux_over: cover property (memMuxEnable && cfg_reg.dir[2] == 1'b0);
  c_pin4_rxc: cover property (cfg_reg.fsel[4] && cfg_reg.dir[4]
    && chanAPin4Sel == PA_P4_RXC);

endmodule
`default_nettype wire

/* verif/pa_pad_model.sv */
/*
  board side of the eight port pads: external drivers and shorts.
  assumes pad drive and enable come straight from the port block.
*/
`timescale 1ns/10ps
`default_nettype none
module pa_pad_model
  import pa_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [PA_PINS-1:0] padOut,
  input  wire logic [PA_PINS-1:0] padOe,
  input  wire logic [PA_PINS-1:0] extLevel,
  input  wire logic [PA_PINS-1:0] extDrive,
  input  wire logic [PA_PINS-1:0] shortMask,
  output logic      [PA_PINS-1:0] padIn
);
  // ****************************************
  // pad resolution
  // ****************************************
  // floating pads wander so a stale level never reads as valid
  logic [PA_PINS-1:0] idle_reg = 8'h00;
  always_ff @(posedge clk) begin
    idle_reg <= ~idle_reg;
  end
  // board stays off any pad the port drives unless told to short it
  always_comb begin
    for (int i = 0; i < PA_PINS; i++) begin
      if (shortMask[i]) begin
        padIn[i] = extLevel[i];
      end else if (padOe[i]) begin
        padIn[i] = padOut[i];
      end else if (extDrive[i]) begin
        padIn[i] = extLevel[i];
      end else begin
        padIn[i] = idle_reg[i];
      end
    end
  end
endmodule
`default_nettype wire

/* verif/port_a_pin_config_tb.sv */
/*
  self-checking bench for the eight-pin port: apb access, pads, routing.
  assumes pa_port_top and the pad model, one 50 mhz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module port_a_pin_config_tb
  import pa_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, errv;
  logic [7:0]  padIn, padOut, padOe;
  logic [7:0]  extLevel = 8'h00, extDrive = 8'hff, shortMask = 8'h00;
  pa_sfout_t   sfOut = 11'h000;
  logic [1:0]  sel4 = 2'h0;
  logic        sel0 = 1'h0, muxEn = 1'h0;
  pa_route_t   route;
  int          nFail = 0, nTests = 0;

  always #10 clk = ~clk;

  pa_port_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .sfOut(sfOut), .chanAPin4Sel(sel4),
    .chanAPin0Sel(sel0), .memMuxEnable(muxEn), .route(route));
  pa_pad_model i_pads (.clk(clk), .padOut(padOut), .padOe(padOe),
    .extLevel(extLevel), .extDrive(extDrive), .shortMask(shortMask),
    .padIn(padIn));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one idle edge after release keeps strobes single-assigned
  task automatic apb(input logic w, input logic [31:0] a, d);
    int k;
    k = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      nFail++;
      wrapUp();
    end
    // values read here are those sampled at the completing edge
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] d);
    apb(1'b1, PA_CFG_ADDR, d);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  function automatic logic [7:0] sfExp(pa_sfout_t s, logic [1:0] s4,
                                       logic s0);
    logic p4;
    p4 = (s4 == PA_P4_AUX1) ? s.chanAAuxOutOne :
         (s4 == PA_P4_RXC) ? s.chanARxClockOut : s.chanAMasterClock;
    return {s.chanATxData, s.chanATerminalReadyN, s.chanARequestSendN, p4,
            s.dmaOneAckOut, s.memAddrMuxStrobe, s.dmaOneFinishedOutN,
            s0 ? s.chanAAuxOutTwo : s.chanAMasterSelectN};
  endfunction

  function automatic pa_route_t rExp(logic [7:0] p);
    return '{p[6], p[4], p[4], p[4], p[3], p[2], p[1], p[0], p[0], p[0],
             p[0]};
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  // entered with rst seen high for two edges; checks, then releases
  task automatic s_reset();
    chk(32'(padOe), 32'h0000_0000);
    chk(32'(padOut), 32'h0000_0000);
    chk(32'(route), 32'(PA_ROUTE_RST));
    rst <= 1'b0;
    settle();
    apb(1'b0, PA_CFG_ADDR, 32'h0000_0000);
    chk(rdv, PA_RD_RST);
  endtask

  task automatic s_gpio();
    extLevel <= 8'h3c;
    settle();
    chk(32'(route), 32'(rExp(8'h3c)));
    apb(1'b0, PA_CFG_ADDR, 32'h0000_0000);
    chk(rdv, 32'h0000_003c);
    wr(32'h00ff_0000);
    wr(32'h00ff_00a5);
    shortMask <= 8'h0f;
    settle();
    chk(32'(padOe), 32'h0000_00ff);
    chk(32'(padOut), 32'h0000_00a5);
    apb(1'b0, PA_CFG_ADDR, 32'h0000_0000);
    chk(rdv, 32'h00ff_00a5);
    shortMask <= 8'h00;
    // value mask follows the config before each write
    wr(32'h0000_00a5);
    wr(32'h0000_00ff);
    wr(32'h00ff_0000);
    settle();
    chk(32'(padOut), 32'h0000_00a5);
    wr(32'h0f3c_0000);
    settle();
    chk(32'(padOe), 32'h0000_003c);
  endtask

  task automatic s_sf_out();
    pa_sfout_t pat;
    wr(32'hffff_0000);
    for (int p = 0; p < 3; p++) begin
      // third pattern tells master clock from rx clock on pin 4
      pat = (p == 0) ? 11'h555 : (p == 1) ? 11'h2aa : 11'h080;
      for (int s = 0; s < 8; s++) begin
        sfOut <= pat;
        sel4 <= s[1:0];
        sel0 <= s[2];
        settle();
        chk(32'(padOut), 32'(sfExp(pat, s[1:0], s[2])));
      end
    end
  endtask

  task automatic s_sf_in();
    wr(32'hff00_0000);
    for (int p = 0; p < 2; p++) begin
      extLevel <= p ? 8'ha5 : 8'h5a;
      settle();
      chk(32'(padOe), 32'h0000_0000);
      chk(32'(route), 32'(rExp(p ? 8'ha5 : 8'h5a)));
      apb(1'b0, PA_CFG_ADDR, 32'h0000_0000);
      chk(rdv, 32'hff00_0000 | 32'(p ? 8'ha5 : 8'h5a));
    end
  endtask

  task automatic s_mux();
    wr(32'h0000_0000);
    muxEn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      sfOut <= p ? 11'h008 : 11'h000;
      settle();
      chk(32'(padOe[2]), 32'h0000_0001);
      chk(32'(padOut[2]), 32'(p));
    end
    muxEn <= 1'b0;
  endtask

  task automatic s_unmapped();
    apb(1'b1, PA_CFG_ADDR + 32'h0000_0004, 32'hffff_ffff);
    chk(32'(errv), 32'h0000_0001);
    apb(1'b0, PA_CFG_ADDR + 32'h0000_0004, 32'h0000_0000);
    chk(32'(errv), 32'h0000_0001);
    chk(rdv, 32'h0000_0000);
    apb(1'b0, PA_CFG_ADDR, 32'h0000_0000);
    chk(32'(errv), 32'h0000_0000);
    chk(rdv & 32'hffff_ff00, 32'h0000_0000);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    s_reset();
    s_gpio();
    s_sf_out();
    extLevel <= 8'h00;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    s_reset();
    s_sf_in();
    s_mux();
    s_unmapped();
    wrapUp();
  end
endmodule
`default_nettype wire
